// File: rtl/wdl_pkg.sv
// package for the low-power watchdog block
package wdl_pkg;
    // register offsets of the plain register port
    localparam logic [3:0] ADDR_PERIOD_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CONTROL = 4'h1;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
    localparam logic [3:0] ADDR_COUNT = 4'h4;
    // period control field positions
    localparam int SEL_LSB = 0;
    localparam int PRESCALE_BIT = 3;
    localparam int ENABLE_BIT = 4;
    // reset values
    localparam logic [4:0] PERIOD_CTRL_RST = 5'h00;
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;
    // base overflow widths in bits
    localparam int BASE_WIDTH_LONG = 14;
    localparam int BASE_WIDTH_SHORT = 10;
    // control register bits
    localparam int CTRL_SERVICE_BIT = 0;
    localparam int CTRL_IDLE_BIT = 1;
    localparam int CTRL_PDOWN_BIT = 2;
    localparam int CTRL_KEEPALIVE_BIT = 3;
    // status bits
    localparam int ST_OVERFLOW = 0;
    localparam int ST_WAKE = 1;
    // length of the reset pulse in cycles
    localparam int RESET_PULSE_CYCLES = 4;

    typedef enum {
        WDL_RUN,
        WDL_PDOWN,
        WDL_WAIT_PIN_HIGH
    } wdl_mode_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } wdl_bus_req_t;
endpackage

// File: rtl/wdl_top.sv
// watchdog counter with power-down, idle and keep-alive handling
`timescale 1ns/100ps
`default_nettype none
module wdl_top #(
    parameter int COUNT_W = 22
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // external level interrupt pin, active low, and its enable
    input wire logic ext_irq_n_i,
    input wire logic ext_irq_en_i,
    // device outputs
    output logic chip_reset_o,
    output logic osc_run_o,
    output logic pdown_o,
    output logic irq_o
);
    initial begin
        if (COUNT_W < 22 || COUNT_W > 30) begin
            $error("wdl_top: COUNT_W must lie in 22..30");
        end
    end

    wdl_pkg::wdl_bus_req_t req;
    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

    // overflow bit index from prescale select and time-out select
    function automatic int unsigned ovf_bit(input logic [4:0] ctl);
        int unsigned base;
        base = ctl[wdl_pkg::PRESCALE_BIT] ? wdl_pkg::BASE_WIDTH_SHORT
                                          : wdl_pkg::BASE_WIDTH_LONG;
        ovf_bit = base + 32'(ctl[wdl_pkg::SEL_LSB +: 3]);
    endfunction

    logic [4:0] period_ctl_ff, nxt_period_ctl;
    logic keepalive_ff, nxt_keepalive;
    logic idle_ff, nxt_idle;
    logic [1:0] status_ff, nxt_status;
    logic [1:0] mask_ff, nxt_mask;
    logic [COUNT_W-1:0] cnt_ff, nxt_cnt;
    wdl_pkg::wdl_mode_t mode_ff, nxt_mode;
    logic [2:0] rst_cnt_ff, nxt_rst_cnt;
    logic chip_reset_ff, nxt_chip_reset;
    logic osc_run_ff, nxt_osc_run;
    logic pdown_ff, nxt_pdown;
    logic irq_ff, nxt_irq;
    logic [7:0] rdata_ff, nxt_rdata;
    logic wake_pending_ff, nxt_wake_pending;

    logic wr_period, wr_ctrl, service, enter_pd, overflow, counting, irq_wake;
    logic [1:0] ev;

    // strobes and event decode
    always_comb begin
        wr_period = req.wr && req.addr == wdl_pkg::ADDR_PERIOD_CTRL;
        wr_ctrl = req.wr && req.addr == wdl_pkg::ADDR_CONTROL;
        service = wr_ctrl && req.wdata[wdl_pkg::CTRL_SERVICE_BIT];
        enter_pd = wr_ctrl && req.wdata[wdl_pkg::CTRL_PDOWN_BIT];
        // level interrupt only wakes while its enable is high in the same cycle
        irq_wake = !ext_irq_n_i && ext_irq_en_i;
        // counter runs in normal and idle, and in power-down only with keep-alive
        counting = period_ctl_ff[wdl_pkg::ENABLE_BIT] && !chip_reset_ff
                   && (mode_ff == wdl_pkg::WDL_RUN
                       || (mode_ff == wdl_pkg::WDL_PDOWN && keepalive_ff));
        overflow = counting && cnt_ff[ovf_bit(period_ctl_ff)];
    end

    // register writes, counter and power mode
    always_comb begin
        nxt_period_ctl = period_ctl_ff;
        nxt_keepalive = keepalive_ff;
        nxt_idle = idle_ff;
        nxt_mask = mask_ff;
        nxt_cnt = cnt_ff;
        nxt_mode = mode_ff;
        nxt_rst_cnt = rst_cnt_ff;
        nxt_chip_reset = chip_reset_ff;
        nxt_wake_pending = 1'b0;
        if (wr_period) begin
            nxt_period_ctl = req.wdata[4:0];
        end
        if (wr_ctrl) begin
            nxt_keepalive = req.wdata[wdl_pkg::CTRL_KEEPALIVE_BIT];
            nxt_idle = req.wdata[wdl_pkg::CTRL_IDLE_BIT];
        end
        if (req.wr && req.addr == wdl_pkg::ADDR_IRQ_MASK) begin
            nxt_mask = req.wdata[1:0];
        end
        // counter: frozen outside counting, cleared on service or overflow
        if (service || overflow) begin
            nxt_cnt = '0;
        end else if (counting) begin
            nxt_cnt = cnt_ff + COUNT_W'(1);
        end
        unique case (mode_ff)
            wdl_pkg::WDL_RUN: begin
                if (enter_pd) begin
                    nxt_mode = wdl_pkg::WDL_PDOWN;
                end
            end
            wdl_pkg::WDL_PDOWN: begin
                if (irq_wake) begin
                    // without keep-alive the count waits for the pin to rise
                    nxt_mode = keepalive_ff ? wdl_pkg::WDL_RUN
                                            : wdl_pkg::WDL_WAIT_PIN_HIGH;
                    nxt_wake_pending = 1'b1;
                end
            end
            wdl_pkg::WDL_WAIT_PIN_HIGH: begin
                if (ext_irq_n_i) begin
                    nxt_mode = wdl_pkg::WDL_RUN;
                end
            end
        endcase
        // overflow gives one reset pulse, leaves power-down, clears period control (disabling the watchdog) and idle
        if (overflow) begin
            nxt_chip_reset = 1'b1;
            nxt_rst_cnt = 3'(wdl_pkg::RESET_PULSE_CYCLES - 1);
            nxt_mode = wdl_pkg::WDL_RUN;
            nxt_period_ctl = wdl_pkg::PERIOD_CTRL_RST;
            nxt_idle = 1'b0;
        end else if (chip_reset_ff) begin
            if (rst_cnt_ff == 3'h0) begin
                nxt_chip_reset = 1'b0;
            end else begin
                nxt_rst_cnt = rst_cnt_ff - 3'h1;
            end
        end
    end

    // sticky status, interrupt output and read data
    always_comb begin
        ev = 2'h0;
        ev[wdl_pkg::ST_OVERFLOW] = overflow;
        ev[wdl_pkg::ST_WAKE] = wake_pending_ff;
        nxt_status = status_ff;
        if (req.wr && req.addr == wdl_pkg::ADDR_IRQ_STATUS) begin
            nxt_status = status_ff & ~req.wdata[1:0];
        end
        // a new event wins over a clear in the same cycle
        nxt_status = nxt_status | ev;
        nxt_irq = |(nxt_status & nxt_mask);
        nxt_osc_run = !(nxt_mode == wdl_pkg::WDL_PDOWN && !nxt_keepalive);
        nxt_pdown = nxt_mode != wdl_pkg::WDL_RUN;
        nxt_rdata = 8'h00;
        if (req.rd) begin
            unique case (req.addr)
                // period control is write only and reads as zero
                wdl_pkg::ADDR_PERIOD_CTRL: nxt_rdata = 8'h00;
                wdl_pkg::ADDR_CONTROL: nxt_rdata = {4'h0, keepalive_ff, pdown_ff, idle_ff, 1'b0};
                wdl_pkg::ADDR_IRQ_STATUS: nxt_rdata = {6'h00, status_ff};
                wdl_pkg::ADDR_IRQ_MASK: nxt_rdata = {6'h00, mask_ff};
                wdl_pkg::ADDR_COUNT: nxt_rdata = cnt_ff[COUNT_W-1 -: 8];
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    // state registers
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            period_ctl_ff <= wdl_pkg::PERIOD_CTRL_RST;
            keepalive_ff <= 1'b0;
            idle_ff <= 1'b0;
            status_ff <= 2'h0;
            mask_ff <= wdl_pkg::IRQ_MASK_RST;
            cnt_ff <= '0;
            mode_ff <= wdl_pkg::WDL_RUN;
            rst_cnt_ff <= 3'h0;
            chip_reset_ff <= 1'b0;
            osc_run_ff <= 1'b1;
            pdown_ff <= 1'b0;
            irq_ff <= 1'b0;
            rdata_ff <= 8'h00;
            wake_pending_ff <= 1'b0;
        end else begin
            period_ctl_ff <= nxt_period_ctl;
            keepalive_ff <= nxt_keepalive;
            idle_ff <= nxt_idle;
            status_ff <= nxt_status;
            mask_ff <= nxt_mask;
            cnt_ff <= nxt_cnt;
            mode_ff <= nxt_mode;
            rst_cnt_ff <= nxt_rst_cnt;
            chip_reset_ff <= nxt_chip_reset;
            osc_run_ff <= nxt_osc_run;
            pdown_ff <= nxt_pdown;
            irq_ff <= nxt_irq;
            rdata_ff <= nxt_rdata;
            wake_pending_ff <= nxt_wake_pending;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign chip_reset_o = chip_reset_ff;
    assign osc_run_o = osc_run_ff;
    assign pdown_o = pdown_ff;
    assign irq_o = irq_ff;
endmodule
`default_nettype wire

// File: verification/wdl_top_sva.sv
// port assertions for the low-power watchdog
`timescale 1ns/100ps
`default_nettype none
module wdl_top_chk #(
    parameter int COUNT_W = 22
) (
    // clock, reset and register port
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // pin and device outputs
    input wire logic ext_irq_n_i,
    input wire logic chip_reset_o,
    input wire logic osc_run_o,
    input wire logic pdown_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    // write-only period control and holes must never leak data
    AST_RD_ZERO: assert property (reg_rd_i && (reg_addr_i == 4'h0 || reg_addr_i > 4'h4)
        |=> reg_rdata_o == 8'h00) else $error("hidden register read gave data");
    AST_RD_QUIET: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data outside the answer cycle");
    AST_RST_PULSE: assert property ($rose(chip_reset_o) |->
        chip_reset_o [*4] ##1 !chip_reset_o) else $error("device reset not four cycles");
    AST_RST_ONCE: assert property ($fell(chip_reset_o) |-> !chip_reset_o [*8])
        else $error("device reset repeated");
    AST_FROZEN: assert property (!osc_run_o |=> !$rose(chip_reset_o))
        else $error("device reset with the oscillator stopped");
    AST_OSC_RUNS: assert property (!pdown_o |-> osc_run_o)
        else $error("oscillator stopped outside power-down");
    AST_PIN_LOW: assert property (!osc_run_o && !ext_irq_n_i |=> pdown_o)
        else $error("counting resumed while the pin is low");
    AST_RST_EXIT: assert property ($rose(chip_reset_o) |-> ##[0:1] !pdown_o)
        else $error("power-down kept through a device reset");
endmodule
bind wdl_top wdl_top_chk #(.COUNT_W(COUNT_W)) u_wdl_chk (.clk_sys_i, .resetn_i, .reg_addr_i,
    .reg_rd_i, .reg_rdata_o, .ext_irq_n_i, .chip_reset_o, .osc_run_o, .pdown_o);
`default_nettype wire

// File: verification/wdl_top_tb.sv
// self-checking bench for the low-power watchdog
`timescale 1ns/100ps
`default_nettype none
module wdl_top_tb;
    localparam logic [3:0] A_PC = wdl_pkg::ADDR_PERIOD_CTRL;
    localparam logic [3:0] A_CT = wdl_pkg::ADDR_CONTROL;
    localparam logic [3:0] A_ST = wdl_pkg::ADDR_IRQ_STATUS;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic ext_irq_n_i = 1'b1;
    logic ext_irq_en_i = 1'b1;
    logic [7:0] reg_rdata_o;
    logic chip_reset_o;
    logic osc_run_o;
    logic pdown_o;
    logic irq_o;
    int miscompares = 0;
    int total_checks = 0;
    int c;
    // rows: address, write data, expected read back
    logic [19:0] rows [6] = '{20'h00700, 20'h30303, 20'h10808, 20'h10202, 20'h5FF00, 20'h30101};
    logic [7:0] pcs [4] = '{8'h18, 8'h19, 8'h1A, 8'h10};
    wdl_top #(.COUNT_W(22)) DUT (.clk_sys_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .ext_irq_n_i, .ext_irq_en_i, .chip_reset_o, .osc_run_o,
        .pdown_o, .irq_o);
    always #10 clk_sys_i = ~clk_sys_i;
    task summarize;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        // let the write settle before any caller samples the outputs
        #1;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, e);
    endtask
    task idle(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    // count cycles to the device reset pulse, then let the pulse pass
    task run(input int n);
        c = 0;
        while (chip_reset_o !== 1'b1 && c < n) begin
            @(posedge clk_sys_i);
            #1 c = c + 1;
        end
        idle(6);
    endtask
    task ovf(input logic [7:0] pc);
        int p;
        p = 1 << ((pc[3] ? wdl_pkg::BASE_WIDTH_SHORT : wdl_pkg::BASE_WIDTH_LONG) + pc[2:0]);
        wr(A_PC, pc);
        run(p + 9);
        chk(8'(c > p - 4 && c < p + 4), 8'h01);
    endtask
    // cut a hang short; the whole run needs well under 40,000 cycles
    initial begin
        #1_000_000;
        miscompares++;
        summarize;
    end
    initial begin
        repeat (6) @(posedge clk_sys_i);
        chk({4'h0, chip_reset_o, osc_run_o, pdown_o, irq_o}, 8'h04);
        resetn_i <= 1'b1;
        rd(A_ST, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i][19:16], rows[i][15:8]);
            rd(rows[i][19:16], rows[i][7:0]);
        end
        // period codes on both bases, interrupt raised and cleared each time
        foreach (pcs[i]) begin
            ovf(pcs[i]);
            chk({7'h0, irq_o}, 8'h01);
            rd(A_ST, 8'h01);
            wr(A_ST, 8'h01);
            chk({7'h0, irq_o}, 8'h00);
        end
        // masked overflow, then the watchdog stays off; idle keeps counting
        wr(wdl_pkg::ADDR_IRQ_MASK, 8'h00);
        ovf(8'h18);
        chk({7'h0, irq_o}, 8'h00);
        run(3000);
        chk(8'(c == 3000), 8'h01);
        wr(A_CT, 8'h02);
        ovf(8'h18);
        // power-down without keep-alive freezes until the pin returns high
        wr(A_CT, 8'h00);
        wr(A_PC, 8'h18);
        wr(A_CT, 8'h05);
        run(2100);
        chk({6'h0, osc_run_o, pdown_o}, 8'h01);
        chk(8'(c == 2100), 8'h01);
        @(posedge clk_sys_i);
        ext_irq_n_i <= 1'b0;
        run(1100);
        chk({7'h0, pdown_o}, 8'h01);
        chk(8'(c == 1100), 8'h01);
        @(posedge clk_sys_i);
        ext_irq_n_i <= 1'b1;
        idle(4);
        chk({7'h0, pdown_o}, 8'h00);
        // overflow bit is still set from the masked overflows above
        rd(A_ST, 8'h03);
        run(1040);
        chk(8'(c > 900 && c < 1030), 8'h01);
        // keep-alive: counting goes on and the overflow ends power-down
        wr(A_CT, 8'h08);
        wr(A_PC, 8'h18);
        wr(A_CT, 8'h0D);
        idle(2);
        chk({6'h0, osc_run_o, pdown_o}, 8'h03);
        run(1040);
        chk(8'(c > 1010 && c < 1030), 8'h01);
        chk({7'h0, pdown_o}, 8'h00);
        wr(A_CT, 8'h0C);
        @(posedge clk_sys_i);
        ext_irq_n_i <= 1'b0;
        idle(3);
        chk({7'h0, pdown_o}, 8'h00);
        wr(A_CT, 8'h09);
        chk({7'h0, chip_reset_o}, 8'h00);
        summarize;
    end
endmodule
`default_nettype wire
